// ### core/rstc_ctrl.sv
// Reset and stop recovery sequencer with reset source status
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module rstc_ctrl
    import rstc_pkg::*;
#(
    parameter int HOLD_XTAL = HOLD_XTAL_CYC,
    parameter int STOP_FILT = STOP_FILT_CYC,
    parameter int PORT_W    = 8
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              supply_above_por,
    input  wire logic              supply_brownout,
    input  wire logic              watchdog_timeout,
    input  wire logic              ext_reset_pin_n,
    input  wire logic              ext_reset_alt_en,
    input  wire logic              debug_pin_n,
    input  wire logic [PORT_W-1:0] port_pins,
    input  wire logic [PORT_W-1:0] stop_recovery_en,
    input  wire logic              stop_mode,
    input  wire logic              ipo_tick,
    input  wire logic              xtal_enable_option,
    input  wire logic              watchdog_reset_select_option,
    input  wire logic              brownout_always_on_option,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    output logic                   cpu_reset_n,
    output logic                   periph_reset_n,
    output logic                   debugger_reset_n,
    output logic                   ctrl_regs_init,
    output logic                   wdt_oscillator_control_reg_init,
    output logic                   port_reset,
    output logic                   reset_pin_out,
    output logic                   reset_pin_oe,
    output logic                   osc_keep_running,
    output logic                   brownout_mon_en,
    output logic                   watchdog_irq,
    output logic                   vector_fetch,
    output logic      [15:0]       vector_addr
);
    localparam logic [CNT_W-1:0] START_LAST = CNT_W'(IPO_START_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST  = CNT_W'(HOLD_IPO_CYC - 1);
    localparam logic [CNT_W-1:0] XTAL_LAST  = CNT_W'(HOLD_XTAL - 1);
    localparam int               SYNC_W     = PORT_W + 3;

    // ==========================================================
    // Helpers
    function automatic logic [3:0] upper_flags(input logic por, input logic stp,
                                               input logic wdt, input logic external_pin_flag);
        upper_flags = {por, stp, wdt, external_pin_flag};
    endfunction

    // ==========================================================
    // Declarations
    rstc_pin_if pin_if ();

    rstc_state_t       state_reg;
    rstc_state_t       state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    logic              smr_reg;
    logic              smr_next;
    logic [3:0]        cause_reg;
    logic [3:0]        cause_next;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [PORT_W-1:0] pins_d_reg;
    logic [7:0]        status_reg;
    logic [7:0]        status_next;
    logic [7:0]        dbg_ctl_reg;
    logic [7:0]        dbg_ctl_next;
    logic              vec_step_reg;

    wire               s_above;
    wire               s_brown;
    wire               s_dbg_n;
    wire [PORT_W-1:0]  s_pins;
    wire               bo_active;
    wire               supply_low;
    wire               wdt_sys;
    wire               wdt_int;
    wire               pin_req;
    wire               dbg_pin_req;
    wire               ocd_req;
    wire               gpio_chg;
    wire               smr_req;
    wire               sys_evt;
    wire               in_run;
    wire               in_rst_next;
    wire               sys_rst_next;
    wire               port_rst_next;
    wire               leaving;
    wire               hold_done;
    wire [CNT_W-1:0]   hold_last;
    wire [3:0]         sys_cause;
    wire [3:0]         smr_cause;
    wire               sel_status;
    wire               sel_dbg;
    wire               rd_status;
    wire [7:0]         rdata_next;

    // ==========================================================
    // Input synchronisation
    assign {s_above, s_brown, s_dbg_n, s_pins} = sync2_reg;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            pins_d_reg <= '0;
        end else begin
            sync1_reg  <= {supply_above_por, supply_brownout, debug_pin_n, port_pins};
            sync2_reg  <= sync1_reg;
            pins_d_reg <= s_pins;
        end
    end

    assign pin_if.pin_raw_n = ext_reset_pin_n;
    assign pin_if.stop_mode = stop_mode;

    rstc_pin_filter #(
        .STOP_FILT (STOP_FILT)
    ) u_pin_filter (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (pin_if.filt)
    );

    // ==========================================================
    // Request decoding
    assign bo_active   = !stop_mode || brownout_always_on_option;
    assign supply_low  = !s_above || (s_brown && bo_active);
    assign wdt_sys     = watchdog_timeout && !stop_mode && watchdog_reset_select_option;
    assign wdt_int     = watchdog_timeout && !stop_mode && !watchdog_reset_select_option;
    assign pin_req     = pin_if.asserted && ext_reset_alt_en;
    assign dbg_pin_req = stop_mode && !s_dbg_n;
    assign ocd_req     = dbg_ctl_reg[DBG_RST_BIT];
    assign gpio_chg    = |((s_pins ^ pins_d_reg) & stop_recovery_en);
    assign smr_req     = stop_mode && (watchdog_timeout || gpio_chg);
    assign sys_evt     = wdt_sys || ocd_req || dbg_pin_req;
    assign in_run      = (state_reg == RSTC_RUN);

    assign sys_cause   = upper_flags(1'b0, 1'b0, wdt_sys, pin_req);
    assign smr_cause   = upper_flags(1'b0, 1'b1, watchdog_timeout, 1'b0);

    // ==========================================================
    // Sequencer
    assign hold_last = xtal_enable_option ? XTAL_LAST : HOLD_LAST;
    assign hold_done = ipo_tick && (cnt_reg >= hold_last);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        smr_next   = smr_reg;
        cause_next = cause_reg;
        if (supply_low) begin
            state_next         = RSTC_SUPPLY;
            smr_next           = 1'b0;
            cause_next         = '0;
            cause_next[ST_POR-4] = 1'b1;
        end else begin
            case (state_reg)
                RSTC_RUN: begin
                    if (sys_evt || pin_req) begin
                        state_next = RSTC_START;
                        cnt_next   = '0;
                        smr_next   = 1'b0;
                        cause_next = sys_cause;
                    end else if (smr_req) begin
                        state_next = RSTC_START;
                        cnt_next   = '0;
                        smr_next   = 1'b1;
                        cause_next = smr_cause;
                    end
                end
                RSTC_SUPPLY: begin
                    state_next = RSTC_START;
                    cnt_next   = '0;
                end
                RSTC_START: begin
                    if (sys_evt && smr_reg) begin
                        cnt_next   = '0;
                        smr_next   = 1'b0;
                        cause_next = sys_cause;
                    end else if (cnt_reg == START_LAST) begin
                        state_next = RSTC_HOLD;
                        cnt_next   = '0;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                RSTC_HOLD: begin
                    if (wdt_sys || dbg_pin_req) begin
                        state_next = RSTC_START;
                        cnt_next   = '0;
                        smr_next   = 1'b0;
                        cause_next = cause_reg | sys_cause;
                    end else if (hold_done) begin
                        state_next = (pin_req && !smr_reg) ? RSTC_PINW : RSTC_RUN;
                        cnt_next   = '0;
                    end else if (ipo_tick) begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                RSTC_PINW: begin
                    if (!pin_if.asserted) begin
                        state_next = RSTC_RUN;
                    end
                end
                default: begin
                    state_next = RSTC_SUPPLY;
                    cnt_next   = '0;
                end
            endcase
        end
    end

    assign in_rst_next  = (state_next != RSTC_RUN);
    assign sys_rst_next = in_rst_next && !smr_next;
    // Pad is let go when the hold ends, else the block would hold its own pin low
    assign port_rst_next = sys_rst_next && (state_next != RSTC_PINW);
    assign leaving      = !in_run && !in_rst_next;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= RSTC_SUPPLY;
            cnt_reg   <= '0;
            smr_reg   <= 1'b0;
            cause_reg <= 4'h8;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            smr_reg   <= smr_next;
            cause_reg <= cause_next;
        end
    end

    // ==========================================================
    // Register port
    assign sel_status = (reg_addr == OFS_STATUS);
    assign sel_dbg    = (reg_addr == OFS_DBG_CTL);
    assign rd_status  = reg_rd && sel_status;
    assign rdata_next = !reg_rd   ? 8'h00 :
                        sel_status ? status_reg :
                        sel_dbg    ? dbg_ctl_reg : 8'h00;

    always_comb begin
        status_next = status_reg;
        if (rd_status) begin
            status_next[7:4] = 4'h0;
        end
        if (leaving) begin
            status_next[7:4] = cause_reg;
        end
    end

    always_comb begin
        dbg_ctl_next = dbg_ctl_reg;
        if (in_rst_next && !smr_next) begin
            dbg_ctl_next[DBG_RST_BIT] = 1'b0;
        end
        if (reg_wr && sel_dbg) begin
            dbg_ctl_next = reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg  <= STATUS_RST;
            dbg_ctl_reg <= DBG_CTL_RST;
            reg_rdata   <= 8'h00;
        end else begin
            status_reg  <= status_next;
            dbg_ctl_reg <= dbg_ctl_next;
            reg_rdata   <= rdata_next;
        end
    end

    // ==========================================================
    // Reset outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_reset_n      <= 1'b0;
            periph_reset_n   <= 1'b0;
            debugger_reset_n <= 1'b0;
            ctrl_regs_init   <= 1'b1;
            wdt_oscillator_control_reg_init <= 1'b1;
            port_reset       <= 1'b1;
            reset_pin_out    <= 1'b0;
            reset_pin_oe     <= 1'b1;
            osc_keep_running <= 1'b1;
            brownout_mon_en  <= 1'b1;
            watchdog_irq     <= 1'b0;
        end else begin
            cpu_reset_n      <= !in_rst_next;
            periph_reset_n   <= !in_rst_next;
            debugger_reset_n <= !(in_rst_next && cause_next[ST_POR-4]);
            ctrl_regs_init   <= sys_rst_next;
            wdt_oscillator_control_reg_init <= in_rst_next;
            port_reset       <= port_rst_next;
            reset_pin_out    <= 1'b0;
            reset_pin_oe     <= port_rst_next;
            osc_keep_running <= 1'b1;
            brownout_mon_en  <= bo_active;
            watchdog_irq     <= wdt_int;
        end
    end

    // ==========================================================
    // Reset vector fetch
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vec_step_reg <= 1'b0;
            vector_fetch <= 1'b0;
            vector_addr  <= VEC_ADDR_HI;
        end else begin
            vec_step_reg <= leaving;
            vector_fetch <= leaving || vec_step_reg;
            vector_addr  <= vec_step_reg ? VEC_ADDR_LO : VEC_ADDR_HI;
        end
    end

endmodule

// ### core/rstc_pkg.sv
// Constants, register map and state codes of the reset and stop recovery controller
package rstc_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int IPO_START_NS   = 4000;
    localparam int IPO_START_CYC  = (IPO_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_IPO_CYC   = 66;
    localparam int HOLD_XTAL_CYC  = 5000;
    localparam int PIN_FILT_CYC   = 3;
    localparam int STOP_FILT_CYC  = 8;
    localparam int CNT_W          = 13;
    localparam int FILT_W         = 8;

    // ==========================================================
    // Register map
    localparam int         ADDR_W      = 4;
    localparam logic [3:0] OFS_STATUS  = 4'h0;
    localparam logic [3:0] OFS_DBG_CTL = 4'h1;
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic [7:0] DBG_CTL_RST = 8'h00;
    localparam int         ST_POR      = 7;
    localparam int         ST_STOP     = 6;
    localparam int         ST_WDT      = 5;
    localparam int         ST_EXT      = 4;
    localparam int         DBG_RST_BIT = 0;

    // ==========================================================
    // Reset vector location
    localparam logic [15:0] VEC_ADDR_HI = 16'h0002;
    localparam logic [15:0] VEC_ADDR_LO = 16'h0003;

    // ==========================================================
    // Sequencer states
    typedef enum logic [4:0] {
        RSTC_RUN    = 5'b00001,
        RSTC_SUPPLY = 5'b00010,
        RSTC_START  = 5'b00100,
        RSTC_HOLD   = 5'b01000,
        RSTC_PINW   = 5'b10000
    } rstc_state_t;

endpackage

// ### core/rstc_pin_if.sv
// Carrier between the sequencer and the reset pin filter
`timescale 1ns/1ps
interface rstc_pin_if;
    logic pin_raw_n;
    logic stop_mode;
    logic asserted;

    modport filt (
        input  pin_raw_n,
        input  stop_mode,
        output asserted
    );
    modport ctrl (
        output pin_raw_n,
        output stop_mode,
        input  asserted
    );
endinterface

// ### core/rstc_pin_filter.sv
// Synchroniser and width filter of the external reset pin
`timescale 1ns/1ps
module rstc_pin_filter
    import rstc_pkg::*;
#(
    parameter int STOP_FILT = STOP_FILT_CYC
) (
    input  wire logic   core_clk,
    input  wire logic   nrst,
    rstc_pin_if.filt    pin
);
    localparam logic [FILT_W-1:0] NORM_LEN = FILT_W'(PIN_FILT_CYC);
    localparam logic [FILT_W-1:0] STOP_LEN = FILT_W'(STOP_FILT);

    logic              sync1_reg;
    logic              sync2_reg;
    logic [FILT_W-1:0] low_cnt_reg;
    logic [FILT_W-1:0] low_cnt_next;
    logic              asserted_reg;
    wire  [FILT_W-1:0] need_len;
    wire               long_enough;

    // Low pulses shorter than the mode's width never assert
    assign need_len     = pin.stop_mode ? STOP_LEN : NORM_LEN;
    assign low_cnt_next = sync2_reg ? '0 :
                          (low_cnt_reg == '1) ? low_cnt_reg : low_cnt_reg + 1'b1;
    assign long_enough  = !sync2_reg && (low_cnt_next >= need_len);
    assign pin.asserted = asserted_reg;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg    <= 1'b1;
            sync2_reg    <= 1'b1;
            low_cnt_reg  <= '0;
            asserted_reg <= 1'b0;
        end else begin
            sync1_reg    <= pin.pin_raw_n;
            sync2_reg    <= sync1_reg;
            low_cnt_reg  <= low_cnt_next;
            asserted_reg <= long_enough;
        end
    end
endmodule

// ### test/rstc_partner.sv
// Far side model: oscillator ticks and the pulled-up reset pad
`timescale 1ns/1ps
module rstc_partner #(
    parameter int TICK = 2
) (
    input  wire logic core_clk,
    input  wire logic pull_n,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output wire logic ipo_tick,
    output wire logic pad_n
);
    int cnt = 0;
    // Oscillator keeps ticking through every reset
    always @(posedge core_clk) cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    assign ipo_tick = (cnt == TICK - 1);
    assign pad_n    = !((pin_oe && !pin_out) || !pull_n);
endmodule

// ### test/rstc_ctrl_chk.sv
// Assertions on the ports of the reset and stop recovery controller
`timescale 1ns/1ps
module rstc_ctrl_chk
    import rstc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        watchdog_timeout,
    input wire logic        stop_mode,
    input wire logic        watchdog_reset_select_option,
    input wire logic        brownout_always_on_option,
    input wire logic        cpu_reset_n,
    input wire logic        periph_reset_n,
    input wire logic        wdt_oscillator_control_reg_init,
    input wire logic        port_reset,
    input wire logic        reset_pin_out,
    input wire logic        reset_pin_oe,
    input wire logic        osc_keep_running,
    input wire logic        brownout_mon_en,
    input wire logic        watchdog_irq,
    input wire logic        vector_fetch,
    input wire logic [15:0] vector_addr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_pin_open_drain: assert property (!reset_pin_out && osc_keep_running)
        else $error("reset pin level or oscillator wrong");
    a_pin_port_rst: assert property (reset_pin_oe == port_reset && (!reset_pin_oe || !cpu_reset_n))
        else $error("reset pin drive outside port reset");
    a_periph_idle: assert property (periph_reset_n == cpu_reset_n)
        else $error("peripherals not idle with the cpu");
    a_stop_init: assert property (!cpu_reset_n |-> wdt_oscillator_control_reg_init)
        else $error("watchdog and oscillator control not reinitialised");
    a_wdt_reset: assert property (watchdog_timeout && watchdog_reset_select_option && !stop_mode
        && cpu_reset_n |-> ##[1:4] !cpu_reset_n) else $error("watchdog timeout gave no reset");
    a_wdt_irq: assert property (watchdog_timeout && !watchdog_reset_select_option && !stop_mode
        && cpu_reset_n |=> watchdog_irq ##1 !watchdog_irq) else $error("watchdog irq missing");
    a_irq_cause: assert property ($rose(watchdog_irq) |->
        $past(watchdog_timeout) && !$past(watchdog_reset_select_option)) else $error("stray irq");
    a_vec_pair: assert property ($rose(vector_fetch) |-> vector_addr == VEC_ADDR_HI ##1
        vector_fetch && vector_addr == VEC_ADDR_LO ##1 !vector_fetch) else $error("vector fetch");
    a_bo_enable: assert property (1'b1 |=> brownout_mon_en ==
        (!$past(stop_mode) || $past(brownout_always_on_option))) else $error("brownout enable");
endmodule
bind rstc_ctrl rstc_ctrl_chk rstc_ctrl_chk_inst (
    .core_clk(core_clk), .nrst(nrst), .watchdog_timeout(watchdog_timeout),
    .stop_mode(stop_mode), .watchdog_reset_select_option(watchdog_reset_select_option),
    .brownout_always_on_option(brownout_always_on_option), .cpu_reset_n(cpu_reset_n),
    .periph_reset_n(periph_reset_n), .wdt_oscillator_control_reg_init(wdt_oscillator_control_reg_init),
    .port_reset(port_reset), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .osc_keep_running(osc_keep_running), .brownout_mon_en(brownout_mon_en),
    .watchdog_irq(watchdog_irq), .vector_fetch(vector_fetch), .vector_addr(vector_addr)
);

// ### test/test_reset_and_stop_recovery_control.sv
// Self-checking testbench of the reset and stop recovery controller
`timescale 1ns/1ps
module test_reset_and_stop_recovery_control
    import rstc_pkg::*;
();
    localparam int HX  = 20;
    localparam int TK  = 2;
    localparam int SYS = IPO_START_CYC + HOLD_IPO_CYC * TK;
    logic        clk = 1'b0, nrst = 1'b0, por_ok = 1'b0, bo = 1'b1, wdt = 1'b0, pull_n = 1'b1;
    logic        alt = 1'b0, dbg_n = 1'b1, stop = 1'b0, xtal = 1'b0, wsel = 1'b1, aon = 1'b0;
    logic        wr = 1'b0, rd = 1'b0;
    logic [7:0]  pins = 8'h00, sren = 8'h00, wd = 8'h00, rdat;
    logic [3:0]  addr = 4'h0;
    logic [15:0] va;
    logic        cpu_n, per_n, dbr_n, cri, woi, prst, pout, poe, osc, boe, irq, vf;
    wire         tick, pad_n;
    int          errors = 0;
    int          tests_run = 0;

    rstc_ctrl #(.HOLD_XTAL(HX)) rstc_ctrl_inst (
        .core_clk(clk), .nrst(nrst), .supply_above_por(por_ok), .supply_brownout(bo),
        .watchdog_timeout(wdt), .ext_reset_pin_n(pad_n), .ext_reset_alt_en(alt),
        .debug_pin_n(dbg_n), .port_pins(pins), .stop_recovery_en(sren), .stop_mode(stop),
        .ipo_tick(tick), .xtal_enable_option(xtal), .watchdog_reset_select_option(wsel),
        .brownout_always_on_option(aon), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdat), .cpu_reset_n(cpu_n), .periph_reset_n(per_n),
        .debugger_reset_n(dbr_n), .ctrl_regs_init(cri), .wdt_oscillator_control_reg_init(woi),
        .port_reset(prst), .reset_pin_out(pout), .reset_pin_oe(poe), .osc_keep_running(osc),
        .brownout_mon_en(boe), .watchdog_irq(irq), .vector_fetch(vf), .vector_addr(va));
    rstc_partner #(.TICK(TK)) rstc_partner_inst (.core_clk(clk), .pull_n(pull_n),
        .pin_out(pout), .pin_oe(poe), .ipo_tick(tick), .pad_n(pad_n));

    initial forever #4 clk = ~clk;
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk("rdata", e, rdat);
    endtask
    // Two status reads back to back: the second sees the cleared flags
    task automatic st_chk(input logic [7:0] e);
        @(posedge clk);
        addr <= OFS_STATUS;
        rd <= 1'b1;
        repeat (2) @(posedge clk);
        rd <= 1'b0;
        chk("status", e, rdat);
        @(posedge clk);
        chk("status clear", 8'h00, rdat);
    endtask
    task automatic wait_low(input int lim);
        for (int i = 0; i < lim && cpu_n !== 1'b0; i++) @(posedge clk);
        chk("entry", 1'b0, cpu_n);
    endtask
    task automatic exit_len(input int e);
        int n;
        n = 0;
        while (cpu_n !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk("hold", 1'b1, n >= e - 6 && n <= e + 8);
    endtask
    task automatic wdt_pulse(input logic sel);
        @(posedge clk);
        wsel <= sel;
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_supply();
        repeat (40) @(posedge clk);
        chk("cpu", 1'b0, cpu_n);
        chk("dbg", 1'b0, dbr_n);
        chk("pin oe", 1'b1, poe);
        chk("port", 1'b1, prst);
        chk("regs", 1'b1, cri);
        bo <= 1'b0;
        por_ok <= 1'b1;
        exit_len(SYS + 3);
        st_chk(8'h80);
    endtask
    task automatic t_dbg();
        @(posedge clk);
        xtal <= 1'b1;
        wr_reg(4'h9, 8'hff);
        rd_chk(4'h9, 8'h00);
        wr_reg(OFS_DBG_CTL, 8'h01);
        wait_low(8);
        chk("dbg kept", 1'b1, dbr_n);
        rd_chk(OFS_DBG_CTL, 8'h00);
        exit_len(IPO_START_CYC + HX * TK - 3);
        xtal <= 1'b0;
        st_chk(8'h00);
    endtask
    task automatic t_wdt();
        logic seen = 1'b0;
        wdt_pulse(1'b1);
        wait_low(8);
        exit_len(SYS);
        st_chk(8'h20);
        wdt_pulse(1'b0);
        for (int i = 0; i < 4; i++) begin
            seen = seen | (irq === 1'b1);
            @(posedge clk);
        end
        chk("irq", 1'b1, seen);
        chk("no reset", 1'b1, cpu_n);
    endtask
    task automatic t_pin();
        @(posedge clk);
        alt <= 1'b1;
        pull_n <= 1'b0;
        repeat (2) @(posedge clk);
        pull_n <= 1'b1;
        repeat (10) @(posedge clk);
        chk("short", 1'b1, cpu_n);
        alt <= 1'b0;
        pull_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk("pin off", 1'b1, cpu_n);
        alt <= 1'b1;
        wait_low(12);
        repeat (SYS + 40) @(posedge clk);
        chk("pin held", 1'b0, cpu_n);
        chk("pin let go", 1'b0, poe);
        pull_n <= 1'b1;
        exit_len(0);
        st_chk(8'h10);
    endtask
    task automatic t_stop();
        @(posedge clk);
        stop <= 1'b1;
        aon <= 1'b0;
        sren <= 8'h01;
        pins <= 8'h02;
        repeat (10) @(posedge clk);
        chk("pin off", 1'b1, cpu_n);
        chk("bo off", 1'b0, boe);
        pull_n <= 1'b0;
        repeat (4) @(posedge clk);
        pull_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk("stop short", 1'b1, cpu_n);
        aon <= 1'b1;
        pins <= 8'h03;
        wait_low(10);
        chk("regs kept", 1'b0, cri);
        stop <= 1'b0;
        exit_len(SYS);
        st_chk(8'h40);
        stop <= 1'b1;
        dbg_n <= 1'b0;
        wait_low(10);
        chk("sys reset", 1'b1, cri);
        stop <= 1'b0;
        dbg_n <= 1'b1;
        exit_len(SYS);
    endtask

    task automatic stop_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_supply();
        t_dbg();
        t_wdt();
        t_pin();
        t_stop();
        stop_test();
    end
    initial begin
        #400000;
        errors++;
        stop_test();
    end
endmodule
